/* File: ucv_unit.sv */
// Truncating unsigned-to-float converter and its flags-only twin
//
// Summary of operation
// - Convert unsigned 32-bit to float, truncating always.
// - Exceptions raised set matching status-word flags.
// - Status flags sticky; only explicit write clears.
// - Flags update on same edge as writeback.
// - Simultaneous flag updates OR with existing value.
// - Guard LSB gates destination write and flags.
// - Flags-only op writes vector, status untouched.
// - Vector bits 6..0 flags, bits 31..7 zero.
// - Flags-only destination written only when guard true.
// - Bits past 24-bit significand dropped, raise inexact.
// - Flags-only uses same toward-zero conversion.
`timescale 1ns/1ps
module ucv_unit
  import ucv_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire ucv_issue_t i_issue,
  input wire logic i_other_fp_valid,
  input wire ucv_flags_t i_other_fp_flags,
  input wire logic i_status_wr_en,
  input wire ucv_flags_t i_status_wr_flags,
  output ucv_wb_t o_wb,
  output ucv_flags_t o_status_flags,
  output logic o_issue_reject
);

  // ==========================================================
  // Helpers
  // ==========================================================
  // Truncating conversion; returns {inexact, float bits}
  function automatic logic [UCV_DATA_W:0] ucv_trunc_cvt(input logic [UCV_DATA_W-1:0] v);
    logic [4:0] msb;
    logic [UCV_DATA_W-1:0] norm;
    logic [7:0] expo;
    msb = 5'h00;
    for (int i = 0; i < UCV_DATA_W; i++) begin
      if (v[i]) begin
        msb = 5'(i);
      end
    end
    norm = v << (5'h1F - msb);
    // Exponent peaks at bias plus 31, so no overflow path is needed
    expo = UCV_EXP_BIAS + {3'h0, msb};
    if (v == '0) begin
      ucv_trunc_cvt = '0;
    end else begin
      // Dropped bits below the significand are the only exception source
      ucv_trunc_cvt = {|norm[7:0], 1'b0, expo, norm[30:8]};
    end
  endfunction

  // Place a flag set into a destination-register word
  function automatic logic [UCV_DATA_W-1:0] ucv_flag_word(input ucv_flags_t f);
    ucv_flag_word = {{(UCV_DATA_W-UCV_FLAG_W){1'b0}}, f};
  endfunction

  // Legal issue slots for this unit
  function automatic logic ucv_slot_ok(input logic [2:0] s);
    ucv_slot_ok = (s == UCV_SLOT_A) || (s == UCV_SLOT_B);
  endfunction

  // ==========================================================
  // Issue decode
  // ==========================================================
  logic is_ours;
  logic take;
  // Other opcodes belong to other units; a bad slot is refused
  assign is_ours = i_issue.valid &&
                   (i_issue.opcode == UCV_OPC_CONVERT || i_issue.opcode == UCV_OPC_FLAGS);
  assign take = is_ours && ucv_slot_ok(i_issue.slot);

  // ==========================================================
  // Stage 1: capture operand and guard
  // ==========================================================
  logic s1_valid_ff, nxt_s1_valid;
  logic s1_flags_op_ff, nxt_s1_flags_op;
  logic [UCV_DATA_W-1:0] s1_src_ff, nxt_s1_src;
  logic [UCV_REG_IDX_W-1:0] s1_dest_ff, nxt_s1_dest;
  logic reject_ff, nxt_reject;

  // A false guard squashes the op here, so neither write nor flags follow
  always_comb begin
    nxt_s1_valid = take && i_issue.guard[0];
    nxt_s1_flags_op = (i_issue.opcode == UCV_OPC_FLAGS);
    nxt_s1_src = take ? i_issue.first_source_register : s1_src_ff;
    nxt_s1_dest = take ? i_issue.dest : s1_dest_ff;
    nxt_reject = is_ours && !ucv_slot_ok(i_issue.slot);
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_valid_ff <= 1'b0;
      s1_flags_op_ff <= 1'b0;
      s1_src_ff <= '0;
      s1_dest_ff <= '0;
      reject_ff <= 1'b0;
    end else begin
      s1_valid_ff <= nxt_s1_valid;
      s1_flags_op_ff <= nxt_s1_flags_op;
      s1_src_ff <= nxt_s1_src;
      s1_dest_ff <= nxt_s1_dest;
      reject_ff <= nxt_reject;
    end
  end

  // ==========================================================
  // Stage 2: conversion
  // ==========================================================
  logic [UCV_DATA_W:0] cvt;
  ucv_flags_t cvt_flags;
  logic s2_valid_ff, nxt_s2_valid;
  logic s2_flags_op_ff, nxt_s2_flags_op;
  logic [UCV_DATA_W-1:0] s2_result_ff, nxt_s2_result;
  ucv_flags_t s2_flags_ff, nxt_s2_flags;
  logic [UCV_REG_IDX_W-1:0] s2_dest_ff, nxt_s2_dest;

  // Both ops share one converter, so their flags cannot disagree
  always_comb begin
    cvt = ucv_trunc_cvt(s1_src_ff);
    cvt_flags = '0;
    cvt_flags.inexact_flag = cvt[UCV_DATA_W];
    nxt_s2_valid = s1_valid_ff;
    nxt_s2_flags_op = s1_flags_op_ff;
    nxt_s2_result = s1_flags_op_ff ? ucv_flag_word(cvt_flags) : cvt[UCV_DATA_W-1:0];
    nxt_s2_flags = cvt_flags;
    nxt_s2_dest = s1_dest_ff;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s2_valid_ff <= 1'b0;
      s2_flags_op_ff <= 1'b0;
      s2_result_ff <= '0;
      s2_flags_ff <= UCV_FLAGS_RST;
      s2_dest_ff <= '0;
    end else begin
      s2_valid_ff <= nxt_s2_valid;
      s2_flags_op_ff <= nxt_s2_flags_op;
      s2_result_ff <= nxt_s2_result;
      s2_flags_ff <= nxt_s2_flags;
      s2_dest_ff <= nxt_s2_dest;
    end
  end

  // ==========================================================
  // Stage 3: writeback and status-word flags
  // ==========================================================
  ucv_wb_t wb_ff, nxt_wb;
  ucv_flags_t status_ff, nxt_status;
  ucv_flags_t own_set;

  // Sets are ORed after the write, so an event in the write cycle survives
  always_comb begin
    own_set = (s2_valid_ff && !s2_flags_op_ff) ? s2_flags_ff : '0;
    nxt_status = i_status_wr_en ? i_status_wr_flags : status_ff;
    nxt_status = nxt_status | own_set;
    if (i_other_fp_valid) begin
      nxt_status = nxt_status | i_other_fp_flags;
    end
    nxt_wb.valid = s2_valid_ff;
    nxt_wb.flags_op = s2_flags_op_ff;
    nxt_wb.dest = s2_dest_ff;
    nxt_wb.data = s2_result_ff;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wb_ff <= '0;
      status_ff <= UCV_FLAGS_RST;
    end else begin
      wb_ff <= nxt_wb;
      status_ff <= nxt_status;
    end
  end

  // Writeback and status outputs come straight from the stage-3 registers; the reject comes from stage 1
  assign o_wb = wb_ff;
  assign o_status_flags = status_ff;
  assign o_issue_reject = reject_ff;

  // ==========================================================
  // Assertions
  // ==========================================================
  // All checks run on the one system clock and sleep through reset
  default clocking ucv_cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);

  logic take_g1;
  logic take_g0;
  assign take_g1 = take && i_issue.guard[0];
  assign take_g0 = take && !i_issue.guard[0];

  // Cycles in which nothing but this unit can move the status word
  logic quiet;
  logic wb_cvt;
  logic bad_slot;
  assign quiet = !i_other_fp_valid && !i_status_wr_en;
  assign wb_cvt = o_wb.valid && !o_wb.flags_op;
  assign bad_slot = is_ours && !ucv_slot_ok(i_issue.slot);

  wb_latency_a: assert property (
    take_g1 |-> ##3 (o_wb.valid && o_wb.dest == $past(i_issue.dest, 3)))
    else $error("writeback not three cycles after a guarded issue");

  guard_false_a: assert property (
    take_g0 |-> ##3 !o_wb.valid)
    else $error("false guard still wrote the destination");

  flags_guard_a: assert property (
    (take_g0 && i_issue.opcode == UCV_OPC_FLAGS) ##2 (!i_status_wr_en && !i_other_fp_valid)
    |=> (o_status_flags == $past(o_status_flags)) && !o_wb.valid)
    else $error("squashed flags op had an effect");

  trunc_max_a: assert property (
    take_g1 && i_issue.opcode == UCV_OPC_CONVERT && i_issue.first_source_register == 32'hFFFFFFFF
    |-> ##3 o_wb.data == 32'h4F7FFFFF && o_status_flags.inexact_flag)
    else $error("all-ones input not truncated or inexact missing");

  exact_none_a: assert property (
    take_g1 && i_issue.opcode == UCV_OPC_FLAGS && i_issue.first_source_register[31:24] == 8'h00
    |-> ##3 o_wb.data == 32'h00000000)
    else $error("exact input raised a flag");

  flag_vec_a: assert property (
    take_g1 && i_issue.opcode == UCV_OPC_FLAGS && i_issue.first_source_register == 32'h7FFFFFFF
    |-> ##3 o_wb.data == 32'h00000002 && o_wb.flags_op)
    else $error("flags vector layout wrong");

  // Earlier writebacks and outside updates are excluded so only this op can set it
  status_same_edge_a: assert property (
    (take_g1 && i_issue.opcode == UCV_OPC_CONVERT && i_issue.first_source_register == 32'hFFFFFFFF
     && !o_status_flags.inexact_flag && quiet)
    ##1 (quiet && !wb_cvt) ##1 !wb_cvt
    |-> !o_status_flags.inexact_flag ##1 o_status_flags.inexact_flag)
    else $error("inexact set before the result was written");

  flags_only_keep_a: assert property (
    (take_g1 && i_issue.opcode == UCV_OPC_FLAGS) ##2 (!i_status_wr_en && !i_other_fp_valid)
    |=> o_status_flags == $past(o_status_flags))
    else $error("flags-only op changed the status word");

  sticky_bits_a: assert property (
    |($past(o_status_flags) & ~o_status_flags) |-> $past(i_status_wr_en))
    else $error("status flag cleared without an explicit write");

  or_merge_a: assert property (
    i_other_fp_valid && !i_status_wr_en
    |=> (o_status_flags & ($past(i_other_fp_flags) | $past(o_status_flags)))
        == ($past(i_other_fp_flags) | $past(o_status_flags)))
    else $error("simultaneous flag updates were not merged");

  slot_refuse_a: assert property (
    is_ours && !ucv_slot_ok(i_issue.slot) |=> o_issue_reject ##2 !o_wb.valid)
    else $error("issue from an illegal slot was not refused");

  // Nothing reaches the register file unless a legal, guarded issue came first
  wb_source_a: assert property (
    o_wb.valid |-> $past(take_g1, 3))
    else $error("writeback without a guarded legal issue");

  // A squashed convert must leave every status bit as it was
  conv_guard_a: assert property (
    (take_g0 && i_issue.opcode == UCV_OPC_CONVERT) ##2 quiet
    |=> o_status_flags == $past(o_status_flags))
    else $error("squashed convert changed the status word");

  // Small values fit the significand and come out exact
  exact_three_a: assert property (
    take_g1 && i_issue.opcode == UCV_OPC_CONVERT && i_issue.first_source_register == 32'h00000003
    |-> ##3 o_wb.data == 32'h40400000)
    else $error("small input not converted exactly");

  // Only inexact can arise here, so every other vector bit stays low
  vec_upper_a: assert property (
    o_wb.valid && o_wb.flags_op |-> (o_wb.data & 32'hFFFFFFFD) == 32'h00000000)
    else $error("flags vector has bits outside the inexact position");

  // The reject pulse only ever follows an issue from an illegal slot
  reject_cause_a: assert property (
    o_issue_reject |-> $past(bad_slot))
    else $error("reject raised without an illegal-slot issue");

  // A lone explicit write loads the word exactly, clearing what it omits
  status_load_a: assert property (
    i_status_wr_en && !i_other_fp_valid && !(s2_valid_ff && !s2_flags_op_ff)
    |=> o_status_flags == $past(i_status_wr_flags))
    else $error("explicit write did not load the status word");

  // A flag raised on the write edge survives the write
  set_wins_a: assert property (
    i_status_wr_en && s2_valid_ff && !s2_flags_op_ff
    |=> (o_status_flags & $past(s2_flags_ff)) == $past(s2_flags_ff))
    else $error("explicit write hid a flag raised in the same cycle");

  cov_convert_inx_c: cover property (
    take_g1 && i_issue.opcode == UCV_OPC_CONVERT ##3 o_status_flags.inexact_flag);
  cov_flags_op_c: cover property (take_g1 && i_issue.opcode == UCV_OPC_FLAGS ##3 o_wb.valid);
  cov_guard_off_c: cover property (take_g0);
  cov_write_and_set_c: cover property (i_status_wr_en && s2_valid_ff && !s2_flags_op_ff);
  cov_merge_same_c: cover property (i_other_fp_valid && s2_valid_ff && !s2_flags_op_ff);

endmodule // ucv_unit

/* File: ucv_pkg.sv */
// Shared types and constants for the truncating unsigned-to-float unit
package ucv_pkg;

  // ==========================================================
  // Operation decode and pipeline timing
  // ==========================================================
  localparam logic [7:0] UCV_OPC_CONVERT = 8'h77; // Convert, writes status flags
  localparam logic [7:0] UCV_OPC_FLAGS = 8'h78;   // Flags-only variant
  localparam logic [2:0] UCV_SLOT_A = 3'h1;       // Legal issue slots
  localparam logic [2:0] UCV_SLOT_B = 3'h4;
  localparam int UCV_LATENCY = 3;                 // Issue edge to writeback edge

  // ==========================================================
  // Float format and exception vector layout
  // ==========================================================
  localparam int UCV_DATA_W = 32;
  localparam int UCV_REG_IDX_W = 7;
  localparam int UCV_MANT_W = 23;
  localparam logic [7:0] UCV_EXP_BIAS = 8'h7F;
  localparam int UCV_FLAG_W = 7;
  localparam int UCV_DBZ_BIT = 0;
  localparam int UCV_INX_BIT = 1;
  localparam int UCV_UNF_BIT = 2;
  localparam int UCV_OVF_BIT = 3;
  localparam int UCV_INV_BIT = 4;
  localparam int UCV_IFZ_BIT = 5;
  localparam int UCV_OFZ_BIT = 6;
  localparam logic [UCV_FLAG_W-1:0] UCV_FLAGS_RST = 7'h00;

  // Exception flags, field order matches bits 6 down to 0
  typedef struct packed {
    logic output_flushed_zero_flag;
    logic input_flushed_zero_flag;
    logic invalid_flag;
    logic overflow_flag;
    logic underflow_flag;
    logic inexact_flag;
    logic divide_by_zero_flag;
  } ucv_flags_t;

  // One issued operation
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [2:0] slot;
    logic [UCV_DATA_W-1:0] guard;
    logic [UCV_DATA_W-1:0] first_source_register;
    logic [UCV_REG_IDX_W-1:0] dest;
  } ucv_issue_t;

  // One register-file writeback
  typedef struct packed {
    logic valid;
    logic flags_op;
    logic [UCV_REG_IDX_W-1:0] dest;
    logic [UCV_DATA_W-1:0] data;
  } ucv_wb_t;

endpackage

/* File: ucv_regfile_model.sv */
// Register file model that takes the unit's writebacks
`timescale 1ns/1ps
module ucv_regfile_model
  import ucv_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire ucv_wb_t i_wb,
  input wire logic [UCV_REG_IDX_W-1:0] i_rd_idx,
  output logic [UCV_DATA_W-1:0] o_rd_data
);
  // ==========================================================
  // Storage
  // ==========================================================
  logic [UCV_DATA_W-1:0] regs_ff [128];

  // Only a valid writeback lands; a squashed op must leave the entry alone
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < 128; i++) begin
        regs_ff[i] <= 32'hA5A5A5A5;
      end
    end else if (i_wb.valid) begin
      regs_ff[i_wb.dest] <= i_wb.data;
    end
  end

  assign o_rd_data = regs_ff[i_rd_idx]; // Read port for the bench
endmodule // ucv_regfile_model

/* File: ucv_unit_test.sv */
// Self-checking bench for the truncating unsigned-to-float unit
`timescale 1ns/1ps
module ucv_unit_test;
  import ucv_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  ucv_issue_t iss = '0;
  logic oth_v = 1'b0;
  ucv_flags_t oth_f = '0;
  logic wr_en = 1'b0;
  ucv_flags_t wr_f = '0;
  ucv_wb_t wb;
  ucv_flags_t st;
  logic rej;
  logic rej_seen;
  logic [6:0] rd_idx = 7'h00;
  logic [31:0] rd_data;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;

  ucv_unit i_ucv_unit (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_issue(iss),
    .i_other_fp_valid(oth_v), .i_other_fp_flags(oth_f), .i_status_wr_en(wr_en),
    .i_status_wr_flags(wr_f), .o_wb(wb), .o_status_flags(st), .o_issue_reject(rej));
  ucv_regfile_model i_ucv_regfile_model (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
    .i_wb(wb), .i_rd_idx(rd_idx), .o_rd_data(rd_data));

  // ==========================================================
  // Clock, timeout and shared helpers
  // ==========================================================
  initial begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  // Whole run needs about a hundred cycles; the ceiling leaves ample margin
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Present one op for a single edge; the reject pulse is caught just after that edge
  task automatic issue_op(logic [7:0] opc, logic [2:0] sl, logic [31:0] g, logic [31:0] s,
      logic [6:0] d);
    @(posedge i_sys_clk);
    iss <= '{valid: 1'b1, opcode: opc, slot: sl, guard: g, first_source_register: s, dest: d};
    @(posedge i_sys_clk);
    iss.valid <= 1'b0;
    #1 rej_seen = rej;
  endtask

  // Issue one op; result sampled in cycle three after the taking edge
  task automatic run_op(logic [7:0] opc, logic [2:0] sl, logic [31:0] g, logic [31:0] s,
      logic [6:0] d);
    issue_op(opc, sl, g, s, d);
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic stat_wr(ucv_flags_t v);
    @(posedge i_sys_clk);
    wr_en <= 1'b1;
    wr_f <= v;
    @(posedge i_sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic test_convert();
    logic [31:0] srcs [6] = '{32'hFFFFFFFF, 32'h3, 32'h7FFFFFFF, 32'h80000000,
      32'h7FFFFFF1, 32'h0};
    logic [31:0] want [6] = '{32'h4F7FFFFF, 32'h40400000, 32'h4EFFFFFF, 32'h4F000000,
      32'h4EFFFFFF, 32'h0};
    logic [5:0] exp_inexact = 6'h15; // Entries 0, 2 and 4 drop bits
    for (int i = 0; i < 6; i++) begin
      stat_wr('0);
      run_op(UCV_OPC_CONVERT, UCV_SLOT_A, 32'h1, srcs[i], 7'(i + 10));
      check("wb valid", 32'h1, {31'h0, wb.valid});
      check("wb data", want[i], wb.data);
      check("wb dest", 32'(i + 10), {25'h0, wb.dest});
      check("wb kind", 32'h0, {31'h0, wb.flags_op});
      check("status", {30'h0, exp_inexact[i], 1'b0}, {25'h0, st});
    end
    $display("test_convert done");
  endtask

  task automatic test_guard();
    stat_wr('0);
    rd_idx <= 7'h0A;
    run_op(UCV_OPC_CONVERT, UCV_SLOT_B, 32'hFFFFFFFE, 32'hFFFFFFFF, 7'h0A);
    check("wb valid", 32'h0, {31'h0, wb.valid});
    check("status", 32'h0, {25'h0, st});
    check("reg kept", 32'h4F7FFFFF, rd_data);
    run_op(UCV_OPC_FLAGS, UCV_SLOT_A, 32'h0, 32'hFFFFFFFF, 7'h0A);
    check("reg kept", 32'h4F7FFFFF, rd_data);
    $display("test_guard done");
  endtask

  task automatic test_flags();
    logic [31:0] srcs [4] = '{32'h7FFFFFFF, 32'h80000000, 32'h3, 32'hFFFFFFFF};
    logic [31:0] want [4] = '{32'h2, 32'h0, 32'h0, 32'h2};
    stat_wr('0);
    for (int i = 0; i < 4; i++) begin
      run_op(UCV_OPC_FLAGS, UCV_SLOT_B, 32'h1, srcs[i], 7'h20);
      check("flags vec", want[i], wb.data);
      check("wb kind", 32'h1, {31'h0, wb.flags_op & wb.valid});
      check("status", 32'h0, {25'h0, st});
    end
    $display("test_flags done");
  endtask

  task automatic test_merge();
    stat_wr('0);
    // Another unit's flags land on the very edge of our writeback
    issue_op(UCV_OPC_CONVERT, UCV_SLOT_A, 32'h1, 32'hFFFFFFFF, 7'h30);
    @(posedge i_sys_clk);
    oth_v <= 1'b1;
    oth_f <= 7'h51;
    @(posedge i_sys_clk);
    oth_v <= 1'b0;
    #1;
    check("wb valid", 32'h1, {31'h0, wb.valid});
    check("status", 32'h53, {25'h0, st});
    // An explicit write on the writeback edge clears old flags but not the new set
    issue_op(UCV_OPC_CONVERT, UCV_SLOT_A, 32'h1, 32'hFFFFFFFF, 7'h31);
    @(posedge i_sys_clk);
    wr_en <= 1'b1;
    wr_f <= 7'h04;
    @(posedge i_sys_clk);
    wr_en <= 1'b0;
    #1;
    check("status", 32'h06, {25'h0, st});
    stat_wr(7'h04);
    check("status", 32'h04, {25'h0, st});
    run_op(UCV_OPC_CONVERT, 3'h2, 32'h1, 32'hFFFFFFFF, 7'h31);
    check("reject", 32'h1, {31'h0, rej_seen});
    check("reject low", 32'h0, {31'h0, rej});
    check("wb valid", 32'h0, {31'h0, wb.valid});
    check("status", 32'h04, {25'h0, st});
    $display("test_merge done");
  endtask

  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    test_convert();
    test_guard();
    test_flags();
    test_merge();
    test_done();
  end
endmodule // ucv_unit_test
